// ===== logic/icpa_regs.vh
// constants for the configuration port access block
`ifndef ICPA_REGS_VH
`define ICPA_REGS_VH
`define ICPA_PORT_STRAP0     16'h03f0
`define ICPA_PORT_STRAP1     16'h0370
`define ICPA_KEY_ENTER       8'h55
`define ICPA_KEY_EXIT        8'haa
`define ICPA_IDX_CFG_CTRL    8'h02
`define ICPA_IDX_WIN_SEL     8'h03
`define ICPA_IDX_LDN         8'h07
`define ICPA_WIN_SEL_STRAP0  8'h01
`define ICPA_WIN_SEL_STRAP1  8'h02
`define ICPA_WIN_EN_BIT      7
`define ICPA_SOFT_RST_BIT    0
`define ICPA_OPEN_LDN        8'h07
`define ICPA_OPEN_LO         8'h82
`define ICPA_OPEN_HI         8'h9a
`define ICPA_WIN0            16'h00e0
`define ICPA_WIN1            16'h00e2
`define ICPA_WIN2            16'h00e4
`define ICPA_WIN3            16'h00ea
`endif

// ===== logic/icpa_ld7_bank.v
// logical device 7 open-mode register storage
`timescale 1ns/1ps
`default_nettype none
module icpa_ld7_bank
(
	// clock and reset
	input  wire       sys_clk,
	input  wire       resetn,
	// soft reset
	input  wire       softRst,
	// access
	input  wire       wrEn,
	input  wire [7:0] addr,
	input  wire [7:0] wrData,
	output wire [7:0] rdData
);
	reg [7:0] mem_q [0:24];
	wire [7:0] off = addr - 8'h82;

	genvar i;
	generate
		for (i = 0; i < 25; i = i + 1)
		begin : g_reg
			localparam [7:0] IDX = i;
			always @(posedge sys_clk or negedge resetn)
			begin
				if (!resetn)
					mem_q[i] <= 8'h00;
				else if (softRst)
					mem_q[i] <= 8'h00;
				else if (wrEn && off == IDX)
					mem_q[i] <= wrData;
			end
		end
	endgenerate

	assign rdData = (off < 8'd25) ? mem_q[off[4:0]] : 8'h00;
endmodule
`default_nettype wire

// ===== logic/icpa_config_port.v
// configuration port access unit on the isa bus
// What this block does
// R1: strap low decodes key/index at 0x03f0, strap high at 0x0370.
// R2: index port and data port, data at index address plus one.
// R3: all i/o decodes are qualified by aen; aen high cycles ignored.
// R4: index and data ports answer only in configuration state.
// R5: power-up loads defaults and enters run state.
// R6: only run and configuration states; run always accepts entry.
// R7: writing 0x55 to key port enters configuration state.
// R8: writing 0xaa to key port returns to run state.
// R9: host enters, programs registers, issues commands, then exits.
// R10: window-select bits 1:0 choose run pair e0, e2, e4 or ea.
// R11: window-select bit 7 enables the run-state pair decode.
// R12: run data port reaches ld7 0x82-0x9a only; else ignored.
// R13: hard reset on supply power-on or reset output pin.
// R14: writing one to control bit 0 clears the ldn register and the ld7 bank; window select and index are kept.
// R15: key port write-only, zero wait, other key values ignored.
`timescale 1ns/1ps
`default_nettype none
`include "icpa_regs.vh"
module icpa_config_port
(
	// clock and reset
	input  wire        sys_clk,
	input  wire        resetn,
	input  wire        resetOut,
	// strap
	input  wire        modeStrap,
	// isa cycle, one-cycle strobes
	input  wire [15:0] isaAddr,
	input  wire        isaAen,
	input  wire        isaIowStb,
	input  wire        isaIorStb,
	input  wire [7:0]  isaWrData,
	output reg  [7:0]  isaRdData,
	output wire        isaRdValid,
	output wire        isaRdyN,
	// status and settings
	output wire        cfgState,
	output wire [7:0]  logicalDevice,
	output wire [7:0]  openIndex
);
	localparam ST_RUN = 1'b0;
	localparam ST_CFG = 1'b1;

	// strap sampling, three stages
	reg  [2:0] strapSync_q;
	reg        strap_q;
	// counts down past the synchroniser before the window select is loaded
	reg  [2:0] strapWait_q;
	wire       hardRst = resetOut; // R13
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			strapSync_q <= 3'b000;
			strap_q     <= 1'b0;
		end
		else
		begin
			strapSync_q <= {strapSync_q[1:0], modeStrap};
			if (strapSync_q[1] == strapSync_q[2])
				strap_q <= strapSync_q[2];
		end
	end

	// decode
	wire [15:0] basePort = strap_q ? `ICPA_PORT_STRAP1
		: `ICPA_PORT_STRAP0; // R1
	reg  [7:0]  winSel_q;
	reg  [15:0] winBase;
	always @*
	begin
		case (winSel_q[1:0]) // R10
			2'b00:   winBase = `ICPA_WIN0;
			2'b01:   winBase = `ICPA_WIN1;
			2'b10:   winBase = `ICPA_WIN2;
			default: winBase = `ICPA_WIN3;
		endcase
	end
	reg  state_q;
	wire hitIdx  = !isaAen && isaAddr == basePort; // R3
	wire hitData = !isaAen && isaAddr == basePort + 16'h0001; // R2
	wire winOn   = winSel_q[`ICPA_WIN_EN_BIT] && state_q == ST_RUN; // R11
	wire hitOIdx = !isaAen && winOn && isaAddr == winBase;
	wire hitOData = !isaAen && winOn
		&& isaAddr == winBase + 16'h0001;

	// key port shares the index address; key writes decoded in both states
	wire keyWr   = hitIdx && isaIowStb; // R15
	wire cfgIdxWr  = state_q == ST_CFG && hitIdx && isaIowStb; // R4
	wire cfgDataWr = state_q == ST_CFG && hitData && isaIowStb; // R4
	wire cfgIdxRd  = state_q == ST_CFG && hitIdx && isaIorStb; // R4
	wire cfgDataRd = state_q == ST_CFG && hitData && isaIorStb; // R4

	// state machine
	reg stateD;
	always @*
	begin
		stateD = state_q;
		case (state_q)
			ST_RUN:
				if (keyWr && isaWrData == `ICPA_KEY_ENTER) // R6 R7
					stateD = ST_CFG;
			ST_CFG:
				if (keyWr && isaWrData == `ICPA_KEY_EXIT) // R8
					stateD = ST_RUN;
			default:
				stateD = ST_RUN;
		endcase
	end

	// registers
	reg [7:0] index_q;
	reg [7:0] ldn_q;
	reg [7:0] oIndex_q;
	wire oInRange = oIndex_q >= `ICPA_OPEN_LO
		&& oIndex_q <= `ICPA_OPEN_HI; // R12
	wire softRst = cfgDataWr && index_q == `ICPA_IDX_CFG_CTRL
		&& isaWrData[`ICPA_SOFT_RST_BIT]; // R14
	wire cfgLd7 = ldn_q == `ICPA_OPEN_LDN && index_q >= `ICPA_OPEN_LO
		&& index_q <= `ICPA_OPEN_HI;
	wire oWr = hitOData && isaIowStb && oInRange; // R12
	wire bankWr = (cfgDataWr && cfgLd7) || oWr;
	wire [7:0] bankAddr = (state_q == ST_CFG) ? index_q : oIndex_q;
	wire [7:0] bankRd;

	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn) // R5 R13
		begin
			state_q     <= ST_RUN;
			index_q     <= 8'h00;
			ldn_q       <= 8'h00;
			oIndex_q    <= 8'h00;
			winSel_q    <= `ICPA_WIN_SEL_STRAP0;
			strapWait_q <= 3'h6;
		end
		else if (hardRst) // R13
		begin
			state_q     <= ST_RUN;
			index_q     <= 8'h00;
			ldn_q       <= 8'h00;
			oIndex_q    <= 8'h00;
			strapWait_q <= 3'h1;
		end
		else
		begin
			state_q <= stateD;
			if (strapWait_q != 3'h0)
				strapWait_q <= strapWait_q - 3'h1;
			if (strapWait_q == 3'h1) // R1
				winSel_q <= strap_q ? `ICPA_WIN_SEL_STRAP1
					: `ICPA_WIN_SEL_STRAP0;
			else if (cfgDataWr && index_q == `ICPA_IDX_WIN_SEL)
				winSel_q <= isaWrData;
			if (cfgIdxWr)
				index_q <= isaWrData;
			if (softRst)
				ldn_q <= 8'h00; // R14
			else if (cfgDataWr && index_q == `ICPA_IDX_LDN)
				ldn_q <= isaWrData;
			if (hitOIdx && isaIowStb)
				oIndex_q <= isaWrData;
		end
	end

	icpa_ld7_bank u_bank
	(
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.softRst (softRst || hardRst),
		.wrEn    (bankWr),
		.addr    (bankAddr),
		.wrData  (isaWrData),
		.rdData  (bankRd)
	);

	// read data, registered
	reg [7:0] cfgRd;
	always @*
	begin
		case (index_q)
			`ICPA_IDX_WIN_SEL: cfgRd = winSel_q;
			`ICPA_IDX_LDN:     cfgRd = ldn_q;
			default:           cfgRd = cfgLd7 ? bankRd : 8'h00;
		endcase
	end
	wire oRd = hitOData && isaIorStb && oInRange; // R12
	wire oIdxRd = hitOIdx && isaIorStb;
	reg  rdValid_q;
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			isaRdData <= 8'h00;
			rdValid_q <= 1'b0;
		end
		else
		begin
			rdValid_q <= cfgIdxRd || cfgDataRd || oRd || oIdxRd;
			if (cfgIdxRd)
				isaRdData <= index_q;
			else if (cfgDataRd)
				isaRdData <= cfgRd;
			else if (oIdxRd)
				isaRdData <= oIndex_q;
			else if (oRd)
				isaRdData <= bankRd;
		end
	end

	assign isaRdValid    = rdValid_q;
	assign isaRdyN       = 1'b0; // R15
	assign cfgState      = state_q;
	assign logicalDevice = ldn_q;
	assign openIndex     = oIndex_q;
endmodule
`default_nettype wire

// ===== verification/icpa_host.sv
// isa host model issuing one-cycle i/o strobes
`timescale 1ns/1ps
`default_nettype none
module icpa_host
(
	// bus
	input  wire        sys_clk,
	input  wire        isaRdValid,
	input  wire [7:0]  isaRdData,
	output reg  [15:0] isaAddr,
	output reg         isaAen,
	output reg         isaIowStb,
	output reg         isaIorStb,
	output reg  [7:0]  isaWrData
);
	reg       rdV;
	reg [7:0] rdD;
	initial
	begin
		{isaAddr, isaAen, isaIowStb, isaIorStb, isaWrData} = 0;
	end
	// released address and data lines show inverted values; aen and strobes go low
	task io(input w, input [15:0] a, input [7:0] d, input e);
	begin
		@(negedge sys_clk);
		{isaAddr, isaWrData, isaAen, isaIowStb, isaIorStb} = {a, d, e, w, !w};
		@(negedge sys_clk);
		rdV = isaRdValid;
		rdD = isaRdData;
		{isaAddr, isaWrData, isaAen, isaIowStb, isaIorStb} = {~a, ~d, 3'h0};
	end
	endtask
endmodule
`default_nettype wire

// ===== verification/icpa_config_port_asserts.sv
// assertions on the configuration port access unit
`timescale 1ns/1ps
`default_nettype none
`include "icpa_regs.vh"
module icpa_config_port_asserts
(
	// watched ports
	input wire        sys_clk,
	input wire        resetn,
	input wire        resetOut,
	input wire        modeStrap,
	input wire [15:0] isaAddr,
	input wire        isaAen,
	input wire        isaIowStb,
	input wire        isaIorStb,
	input wire [7:0]  isaWrData,
	input wire        isaRdValid,
	input wire        isaRdyN,
	input wire        cfgState,
	input wire [7:0]  logicalDevice
);
	wire [15:0] port = modeStrap ? `ICPA_PORT_STRAP1 : `ICPA_PORT_STRAP0;
	wire        wr = isaIowStb && !isaAen && !resetOut && isaAddr == port;
	wire        rd = isaIorStb && !isaAen && !resetOut;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	no_wait_a: assert property (isaRdyN == 1'b0) else $error("wait");
	key_enter_a: assert property (wr && isaWrData == `ICPA_KEY_ENTER
		|=> cfgState) else $error("enter");
	key_exit_a: assert property (wr && isaWrData == `ICPA_KEY_EXIT
		|=> !cfgState) else $error("exit");
	bad_key_a: assert property (!cfgState && wr && isaWrData != 8'h55
		|=> !cfgState) else $error("bad key");
	aen_ignore_a: assert property (isaAen && !resetOut
		|=> !isaRdValid && $stable(cfgState)) else $error("aen");
	run_silent_a: assert property (!cfgState && isaIorStb
		&& isaAddr[15:1] == port[15:1] |=> !isaRdValid) else $error("run");
	cfg_read_a: assert property (cfgState && rd && isaAddr == port + 16'h1
		|=> isaRdValid) else $error("data port");
	hard_rst_a: assert property (resetOut
		|=> !cfgState && logicalDevice == 8'h00) else $error("hard reset");
endmodule
bind icpa_config_port icpa_config_port_asserts icpa_config_port_asserts_i
	(.sys_clk, .resetn, .resetOut, .modeStrap, .isaAddr, .isaAen, .isaIowStb,
	.isaIorStb, .isaWrData, .isaRdValid, .isaRdyN, .cfgState, .logicalDevice);
`default_nettype wire

// ===== verification/isa_config_port_access_test.sv
// randomised bench for the configuration port access unit
`timescale 1ns/1ps
`default_nettype none
`include "icpa_regs.vh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin err_count++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module isa_config_port_access_test;
	reg         sys_clk = 0, resetn = 0, resetOut = 0, modeStrap = 0;
	wire [15:0] isaAddr;
	wire [7:0]  isaWrData, isaRdData, logicalDevice, openIndex;
	wire        isaAen, isaIowStb, isaIorStb, isaRdValid, isaRdyN, cfgState;
	wire [15:0] port = modeStrap ? `ICPA_PORT_STRAP1 : `ICPA_PORT_STRAP0;
	integer     err_count = 0, comparisons = 0, s, w, seed = 32'hf315;
	reg [7:0]   i, d;
	icpa_config_port icpa_config_port_i (.sys_clk, .resetn, .resetOut,
		.modeStrap, .isaAddr, .isaAen, .isaIowStb, .isaIorStb, .isaWrData,
		.isaRdData, .isaRdValid, .isaRdyN, .cfgState, .logicalDevice, .openIndex);
	icpa_host icpa_host_i (.sys_clk, .isaRdValid, .isaRdData, .isaAddr,
		.isaAen, .isaIowStb, .isaIorStb, .isaWrData);
	function [15:0] win(input [1:0] x);
		win = x == 0 ? `ICPA_WIN0 : x == 1 ? `ICPA_WIN1 : x == 2 ? `ICPA_WIN2 : `ICPA_WIN3;
	endfunction
	task cfg(input [7:0] x, input [7:0] y);
	begin
		icpa_host_i.io(1, port, x, 0);
		icpa_host_i.io(1, port + 16'h1, y, 0);
	end
	endtask
	task tally_and_finish;
	begin
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask
	initial
	begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	initial
	begin
		#50000 err_count++;
		tally_and_finish;
	end
	initial
	begin
		for (s = 0; s < 2; s++)
		begin
			@(negedge sys_clk) resetn = 0;
			modeStrap = s;
			repeat (4) @(negedge sys_clk);
			resetn = 1;
			repeat (5) @(negedge sys_clk);
			`CHK("power-up state", 1'b0, cfgState)
			icpa_host_i.io(0, port + 16'h1, 0, 0);
			`CHK("run data", 1'b0, icpa_host_i.rdV)
			icpa_host_i.io(1, port, `ICPA_KEY_ENTER, 1);
			`CHK("aen key", 1'b0, cfgState)
			icpa_host_i.io(1, port, $random(seed) & 8'h3f, 0);
			`CHK("bad key", 1'b0, cfgState)
			icpa_host_i.io(1, port, `ICPA_KEY_ENTER, 0);
			`CHK("enter", 1'b1, cfgState)
			icpa_host_i.io(1, port, `ICPA_IDX_WIN_SEL, 0);
			icpa_host_i.io(0, port + 16'h1, 0, 0);
			`CHK("win rst", s ? 8'h02 : 8'h01, icpa_host_i.rdD)
			cfg(`ICPA_IDX_LDN, 8'h07);
			cfg(`ICPA_IDX_CFG_CTRL, 8'h01);
			`CHK("soft rst", 8'h00, logicalDevice)
			for (w = 0; w < 5; w++)
			begin
				cfg(`ICPA_IDX_WIN_SEL, w < 4 ? 8'h80 | w : 8'h00);
				icpa_host_i.io(1, port, `ICPA_KEY_EXIT, 0);
				`CHK("exit", 1'b0, cfgState)
				i = w == 0 ? 8'h82 : w == 3 ? 8'h9a : 8'h82 + {$random(seed)} % 25;
				d = $random(seed);
				icpa_host_i.io(1, win(w), i, 0);
				icpa_host_i.io(1, win(w) + 16'h1, d, 0);
				icpa_host_i.io(0, win(w) + 16'h1, 0, 0);
				`CHK("open rd", w < 4, icpa_host_i.rdV)
				if (w < 4) `CHK("open data", d, icpa_host_i.rdD)
				if (w < 4) `CHK("open index", i, openIndex)
				icpa_host_i.io(1, win(w), w[0] ? 8'h9b : 8'h81, 0);
				icpa_host_i.io(0, win(w) + 16'h1, 0, 0);
				`CHK("open out", 1'b0, icpa_host_i.rdV)
				icpa_host_i.io(1, port, `ICPA_KEY_ENTER, 0);
			end
			@(negedge sys_clk) resetOut = 1;
			@(negedge sys_clk) resetOut = 0;
			`CHK("hard rst", 1'b0, cfgState)
			$display("strap %0d test done", s);
		end
		tally_and_finish;
	end
endmodule
`default_nettype wire
